//--- adc_channel_range_sequencer.sv
// channel range settings, filter select and channel sequencer behind apb
`timescale 1ns/1ns

// Behaviour
// R01 - each channel keeps its own range code
// R02 - expand bit picks larger full-scale of pair
// R03 - codes 000/001/010 bipolar single-ended ranges
// R04 - codes 011/100/111 bipolar differential ranges
// R05 - codes 101/110 unipolar single-ended ranges
// R06 - one shared two-bit filter bandwidth field
// R07 - convert selected pair into 16-bit result
// R08 - converted channel is the selector's channel
// R09 - manual mode converts the register-written channel
// R10 - auto-scan advances at each frame falling edge
// R11 - auto-scan visits enabled channels ascending only; with none enabled it stays on the current channel
// R12 - sample on frame fall, channel set before
// R13 - results kept as straight binary
// R14 - auto-scan wraps to lowest enabled channel
// R15 - filter code one is high, else low
module adc_channel_range_sequencer #(
  parameter int NUM_CHANNELS = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic frame_select_n,
  input wire logic [15:0] conv_result,
  output logic [2:0] channel_selector_sel,
  output logic sample_strobe,
  output logic conv_start,
  output logic conv_busy,
  output logic [15:0] result_data,
  output logic result_valid,
  output logic [2:0] active_channel,
  output logic active_bipolar,
  output logic active_differential,
  output logic [1:0] active_range_pair,
  output logic active_range_expand,
  output logic [NUM_CHANNELS*4-1:0] channel_range_code,
  output logic [NUM_CHANNELS-1:0] channel_range_expand,
  output logic filter_high_bandwidth
);

  // ---------------------------------------------------------------
  // elaboration check
  // ---------------------------------------------------------------
  // the channel field is three bits wide, so at most eight channels fit
  generate
    if (NUM_CHANNELS < 1 || NUM_CHANNELS > adc_seq_pkg::MAX_CHANNELS)
    begin : g_bad_channels
      $error("NUM_CHANNELS must be between 1 and 8");
    end
  endgenerate

  // ---------------------------------------------------------------
  // frame select synchroniser and falling edge
  // ---------------------------------------------------------------
  logic fs_meta_reg; // first stage, read only by the second
  logic fs_sync_reg; // second stage, safe to use
  logic fs_prev_reg; // delayed copy for edge detect
  wire fs_fall = fs_prev_reg & ~fs_sync_reg; // frame starts here

  // two flops because the frame pin is asynchronous to pclk
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fs_meta_reg <= 1'b1;
      fs_sync_reg <= 1'b1;
      fs_prev_reg <= 1'b1;
    end
    else
    begin
      fs_meta_reg <= frame_select_n;
      fs_sync_reg <= fs_meta_reg;
      fs_prev_reg <= fs_sync_reg;
    end
  end

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  wire [5:0] reg_idx = paddr[7:2]; // word index
  wire aligned = (paddr[1:0] == 2'h0);
  wire setup_phase = psel & ~penable;
  wire access_phase = psel & penable;
  wire [5:0] range_off = reg_idx - adc_seq_pkg::IDX_RANGE_FIRST;
  wire hit_range = aligned && (reg_idx >= adc_seq_pkg::IDX_RANGE_FIRST) &&
                   (reg_idx <= adc_seq_pkg::IDX_RANGE_LAST);
  wire hit_expand = aligned && (reg_idx == adc_seq_pkg::IDX_EXPAND);
  wire hit_filter = aligned && (reg_idx == adc_seq_pkg::IDX_FILTER);
  wire hit_ctrl = aligned && (reg_idx == adc_seq_pkg::IDX_SEQ_CTRL);
  wire hit_scan = aligned && (reg_idx == adc_seq_pkg::IDX_SCAN_EN);
  wire hit_status = aligned && (reg_idx == adc_seq_pkg::IDX_STATUS);
  wire hit_any = hit_range | hit_expand | hit_filter | hit_ctrl | hit_scan | hit_status;
  wire wr_en = access_phase & pwrite & hit_any; // write lands at the access edge

  // zero wait states; unmapped or misaligned addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = access_phase & ~hit_any;

  // ---------------------------------------------------------------
  // configuration storage
  // ---------------------------------------------------------------
  logic [3:0] range_code_reg [NUM_CHANNELS]; // per-channel range code
  logic [NUM_CHANNELS-1:0] expand_reg; // per-channel expand bits
  logic [1:0] filter_reg; // shared bandwidth field
  adc_seq_pkg::seq_mode_t mode_reg; // manual or auto-scan
  logic [2:0] manual_channel_select_reg; // channel written by the host
  logic [NUM_CHANNELS-1:0] scan_en_reg; // auto-scan enables

  // one storage slot per channel; a write touches only its own slot
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CHANNELS; gi++)
    begin : g_range
      wire sel_me = wr_en & hit_range & (range_off == 6'(gi)); // R01
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          range_code_reg[gi] <= adc_seq_pkg::RST_RANGE_CODE;
        else if (sel_me)
          range_code_reg[gi] <= pwdata[3:0]; // R01
      end
      assign channel_range_code[gi*4 +: 4] = range_code_reg[gi];
    end
  endgenerate

  assign channel_range_expand = expand_reg;

  // shared settings and sequencer control
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      expand_reg <= adc_seq_pkg::RST_EXPAND[NUM_CHANNELS-1:0];
      filter_reg <= adc_seq_pkg::RST_FILTER;
      mode_reg <= adc_seq_pkg::MODE_MANUAL;
      manual_channel_select_reg <= 3'h0;
      scan_en_reg <= adc_seq_pkg::RST_SCAN_EN[NUM_CHANNELS-1:0];
    end
    else if (wr_en)
    begin
      if (hit_expand)
        expand_reg <= pwdata[NUM_CHANNELS-1:0]; // R02
      if (hit_filter)
        filter_reg <= pwdata[1:0]; // R06
      if (hit_ctrl)
      begin
        mode_reg <= adc_seq_pkg::seq_mode_t'(pwdata[adc_seq_pkg::SEQ_MODE_BIT]);
        manual_channel_select_reg <= pwdata[adc_seq_pkg::SEQ_CH_LSB +: 3];
      end
      if (hit_scan)
        scan_en_reg <= pwdata[NUM_CHANNELS-1:0]; // R11
    end
  end

  // ---------------------------------------------------------------
  // filter bandwidth
  // ---------------------------------------------------------------
  // unused codes fall back to the narrow filter, the quieter choice
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      filter_high_bandwidth <= 1'b0;
    else
      filter_high_bandwidth <= (filter_reg == adc_seq_pkg::FILTER_HIGH_CODE); // R06 R15
  end

  // ---------------------------------------------------------------
  // channel sequencer
  // ---------------------------------------------------------------
  // next enabled channel above cur, wrapping to the lowest; stays put when none enabled
  function automatic logic [2:0] next_enabled(input logic [2:0] cur, input logic [NUM_CHANNELS-1:0] en);
    logic [2:0] res;
    logic found;
    int c;
    res = cur;
    found = 1'b0;
    for (int k = 1; k <= NUM_CHANNELS; k++)
    begin
      c = (int'(cur) + k) % NUM_CHANNELS;
      if (!found && en[c])
      begin
        res = 3'(c);
        found = 1'b1;
      end
    end
    return res;
  endfunction : next_enabled

  logic [2:0] cur_channel_reg; // channel the selector presents
  logic [2:0] cur_channel_next;
  wire manual_write = wr_en & hit_ctrl & ~pwdata[adc_seq_pkg::SEQ_MODE_BIT];

  // a host write in manual mode takes over; auto-scan steps only after a sample
  always_comb
  begin
    cur_channel_next = cur_channel_reg;
    if (manual_write)
      cur_channel_next = pwdata[adc_seq_pkg::SEQ_CH_LSB +: 3]; // R09
    else if (fs_fall && mode_reg == adc_seq_pkg::MODE_AUTO)
      cur_channel_next = next_enabled(cur_channel_reg, scan_en_reg); // R10 R11 R14
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cur_channel_reg <= 3'h0;
    else
      cur_channel_reg <= cur_channel_next;
  end

  // the selector shows the channel chosen during the previous frame
  assign channel_selector_sel = cur_channel_reg; // R08 R12

  // ---------------------------------------------------------------
  // range decode of the channel being sampled
  // ---------------------------------------------------------------
  // code to mode and range pair; bit 3 of the stored code is ignored
  wire [2:0] sel_code = range_code_reg[cur_channel_reg][2:0]; // low bits of the sampled channel's code
  wire dec_bipolar = !((sel_code == adc_seq_pkg::RC_UNI_LARGE) || (sel_code == adc_seq_pkg::RC_UNI_MID)); // R03 R05
  wire dec_diff = (sel_code == adc_seq_pkg::RC_DIFF_LARGE) || (sel_code == adc_seq_pkg::RC_DIFF_MID) || // R04
                  (sel_code == adc_seq_pkg::RC_DIFF_SMALL);
  wire dec_mid = (sel_code == adc_seq_pkg::RC_SE_MID) || (sel_code == adc_seq_pkg::RC_DIFF_MID) ||
                 (sel_code == adc_seq_pkg::RC_UNI_MID); // middle pair of any mode
  wire dec_small = (sel_code == adc_seq_pkg::RC_SE_SMALL) || (sel_code == adc_seq_pkg::RC_DIFF_SMALL);
  wire [1:0] dec_pair = dec_small ? adc_seq_pkg::PAIR_SMALL :
                        dec_mid ? adc_seq_pkg::PAIR_MID : adc_seq_pkg::PAIR_LARGE; // R03 R04 R05

  // ---------------------------------------------------------------
  // sample capture and conversion timing
  // ---------------------------------------------------------------
  adc_seq_pkg::conv_state_t conv_state_reg;
  logic [3:0] conv_cnt_reg; // cycles spent so far in the conversion
  wire conv_last = (conv_cnt_reg == 4'(adc_seq_pkg::CONV_CYCLES - 1));

  // a new frame edge restarts the conversion even if one is running
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      conv_state_reg <= adc_seq_pkg::CONV_IDLE;
      conv_cnt_reg <= 4'h0;
    end
    else if (fs_fall)
    begin
      conv_state_reg <= adc_seq_pkg::CONV_BUSY; // R12
      conv_cnt_reg <= 4'h0;
    end
    else
    begin
      case (conv_state_reg)
        adc_seq_pkg::CONV_IDLE: conv_cnt_reg <= 4'h0;
        adc_seq_pkg::CONV_BUSY:
        begin
          if (conv_last)
            conv_state_reg <= adc_seq_pkg::CONV_IDLE;
          conv_cnt_reg <= conv_cnt_reg + 4'h1;
        end
        default: conv_state_reg <= adc_seq_pkg::CONV_IDLE;
      endcase
    end
  end

  wire conv_done = (conv_state_reg == adc_seq_pkg::CONV_BUSY) && conv_last && !fs_fall;
  assign conv_busy = (conv_state_reg == adc_seq_pkg::CONV_BUSY);

  // latch the sampled channel's settings at the frame edge, the result at the end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sample_strobe <= 1'b0;
      conv_start <= 1'b0;
      active_channel <= 3'h0;
      active_bipolar <= 1'b1;
      active_differential <= 1'b0;
      active_range_pair <= adc_seq_pkg::PAIR_LARGE;
      active_range_expand <= 1'b0;
      result_data <= 16'h0000;
      result_valid <= 1'b0;
    end
    else
    begin
      sample_strobe <= fs_fall;
      conv_start <= fs_fall;
      if (fs_fall)
      begin
        active_channel <= cur_channel_reg; // R08 R09
        active_bipolar <= dec_bipolar;
        active_differential <= dec_diff;
        active_range_pair <= dec_pair;
        active_range_expand <= expand_reg[cur_channel_reg]; // R02
        result_valid <= 1'b0;
      end
      else if (conv_done)
      begin
        result_data <= conv_result; // R07 R13
        result_valid <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  // registers other than status are narrower than the bus; their upper bits read as zero
  wire range_ok = hit_range && (range_off < 6'(NUM_CHANNELS)); // slots past the channel count read zero
  wire [31:0] rd_ctrl = (32'(mode_reg) << adc_seq_pkg::SEQ_MODE_BIT) |
                        (32'(manual_channel_select_reg) << adc_seq_pkg::SEQ_CH_LSB);
  wire [31:0] rd_status = (32'(cur_channel_reg) << adc_seq_pkg::ST_CUR_LSB) |
                          (32'(active_channel) << adc_seq_pkg::ST_LAST_LSB) |
                          (32'(conv_busy) << adc_seq_pkg::ST_BUSY_BIT) |
                          (32'(result_data) << adc_seq_pkg::ST_RESULT_LSB);
  wire [31:0] rd_mux = range_ok ? 32'(range_code_reg[range_off[2:0]]) :
                       hit_expand ? 32'(expand_reg) :
                       hit_filter ? 32'(filter_reg) :
                       hit_ctrl ? rd_ctrl :
                       hit_scan ? 32'(scan_en_reg) :
                       hit_status ? rd_status : 32'h0000_0000;

  // captured in the setup cycle so the access phase sees a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (setup_phase && !pwrite)
      prdata <= rd_mux;
  end

endmodule : adc_channel_range_sequencer

//--- adc_seq_pkg.sv
// constants and types shared by the channel range sequencer
package adc_seq_pkg;

  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [5:0] IDX_RANGE_FIRST = 6'h05; // channel_range_select_a
  localparam logic [5:0] IDX_RANGE_LAST = 6'h0C; // channel_range_select_h
  localparam logic [5:0] IDX_EXPAND = 6'h0D; // range_expand_bits
  localparam logic [5:0] IDX_FILTER = 6'h0E; // filter_bandwidth_config
  localparam logic [5:0] IDX_SEQ_CTRL = 6'h10; // sequencer mode and manual channel
  localparam logic [5:0] IDX_SCAN_EN = 6'h11; // auto-scan channel enables
  localparam logic [5:0] IDX_STATUS = 6'h12; // read-only sequencer state

  // ---------------------------------------------------------------
  // field layout
  // ---------------------------------------------------------------
  localparam int CH_W = 3; // channel number width
  localparam int MAX_CHANNELS = 8; // register map room for channels
  localparam int CODE_W = 4; // stored range code width
  localparam int RESULT_W = 16; // conversion result width
  localparam int SEQ_MODE_BIT = 0; // seq_ctrl: 1 = auto-scan
  localparam int SEQ_CH_LSB = 4; // seq_ctrl: manual channel field
  localparam int ST_CUR_LSB = 0; // status: channel on the selector
  localparam int ST_LAST_LSB = 4; // status: channel last sampled
  localparam int ST_BUSY_BIT = 8; // status: conversion running
  localparam int ST_RESULT_LSB = 16; // status: last result

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [3:0] RST_RANGE_CODE = 4'h0;
  localparam logic [7:0] RST_EXPAND = 8'h00;
  localparam logic [1:0] RST_FILTER = 2'h0;
  localparam logic [7:0] RST_SCAN_EN = 8'hFF;
  localparam logic [1:0] FILTER_HIGH_CODE = 2'h1; // only this code picks 35 kHz

  // ---------------------------------------------------------------
  // range code encodings (low three bits)
  // ---------------------------------------------------------------
  localparam logic [2:0] RC_SE_LARGE = 3'h0;
  localparam logic [2:0] RC_SE_MID = 3'h1;
  localparam logic [2:0] RC_SE_SMALL = 3'h2;
  localparam logic [2:0] RC_DIFF_LARGE = 3'h3;
  localparam logic [2:0] RC_DIFF_MID = 3'h4;
  localparam logic [2:0] RC_UNI_LARGE = 3'h5;
  localparam logic [2:0] RC_UNI_MID = 3'h6;
  localparam logic [2:0] RC_DIFF_SMALL = 3'h7;
  localparam logic [1:0] PAIR_LARGE = 2'h0; // 3 / 2.5 x ref
  localparam logic [1:0] PAIR_MID = 2'h1; // 1.5 / 1.25 x ref
  localparam logic [1:0] PAIR_SMALL = 2'h2; // 0.75 / 0.625 x ref

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int CONV_TIME_NS = 880; // longest conversion time
  localparam int CONV_CYCLES_RAW = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int CONV_CYCLES = (CONV_CYCLES_RAW < 1) ? 1 : CONV_CYCLES_RAW;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic {MODE_MANUAL = 1'b0, MODE_AUTO = 1'b1} seq_mode_t;
  typedef enum logic {CONV_IDLE = 1'b0, CONV_BUSY = 1'b1} conv_state_t;

endpackage : adc_seq_pkg

//--- adc_seq_chk.sv
// assertions on the port timing of the channel range sequencer
`timescale 1ns/1ns
module adc_seq_chk #(
  parameter int NUM_CHANNELS = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sample_strobe,
  input wire logic conv_start,
  input wire logic conv_busy,
  input wire logic [15:0] conv_result,
  input wire logic [15:0] result_data,
  input wire logic result_valid,
  input wire logic [2:0] channel_selector_sel,
  input wire logic [2:0] active_channel,
  input wire logic active_differential,
  input wire logic active_range_expand,
  input wire logic [NUM_CHANNELS*4-1:0] channel_range_code,
  input wire logic [NUM_CHANNELS-1:0] channel_range_expand
);
  // ------------------------------------------------
  // single pclk domain, quiet while reset is low
  // ------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_strobe_pair: assert property (sample_strobe == conv_start)
    else $error("sample and start strobes differ");
  // eight busy cycles unless a new frame restarts the count
  a_busy_span: assert property (sample_strobe |->
    (conv_busy [*8] ##1 (!conv_busy || sample_strobe)) or (##[1:7] sample_strobe))
    else $error("conversion length wrong");
  a_result_copy: assert property ($fell(conv_busy) |-> result_valid && result_data == $past(conv_result))
    else $error("result not a copy of the core output");
  a_valid_clear: assert property (sample_strobe |-> !result_valid)
    else $error("result still valid after frame start");
  a_active_hold: assert property (!sample_strobe |-> $stable(active_channel))
    else $error("active channel moved between frames");
  // selector value seen at the frame edge decides the channel
  a_active_sel: assert property (sample_strobe |-> active_channel == $past(channel_selector_sel))
    else $error("active channel is not the selector channel");
  a_expand_sel: assert property (
    sample_strobe |-> active_range_expand == $past(channel_range_expand[channel_selector_sel]))
    else $error("expand bit not taken from the sampled channel");
  a_diff_decode: assert property (
    sample_strobe |-> active_differential ==
    ($past(channel_range_code[channel_selector_sel*4 +: 3]) inside {3'h3, 3'h4, 3'h7}))
    else $error("differential decode wrong");
endmodule : adc_seq_chk
bind adc_channel_range_sequencer adc_seq_chk #(.NUM_CHANNELS(NUM_CHANNELS)) u_adc_seq_chk (.pclk, .presetn,
  .sample_strobe, .conv_start, .conv_busy, .conv_result, .result_data, .result_valid, .channel_selector_sel,
  .active_channel, .active_differential, .active_range_expand, .channel_range_code, .channel_range_expand);

//--- adc_core_model.sv
// behavioural converter core answering the sequencer
`timescale 1ns/1ns
module adc_core_model #(
  parameter logic [15:0] BASE = 16'hC3A0
) (
  input wire logic conv_busy,
  input wire logic [2:0] active_channel,
  output logic [15:0] conv_result
);
  // the code carries the channel, so a wrong channel shows in the result
  // outside a conversion the output is not valid: drive the inverse
  assign conv_result = conv_busy ? (BASE | {13'h0000, active_channel})
                                 : ~(BASE | {13'h0000, active_channel});
endmodule : adc_core_model

//--- testbench.sv
// self-checking bench for the channel range sequencer
`timescale 1ns/1ns
module testbench;
  // ------------------------------------------------
  // connections
  // ------------------------------------------------
  localparam logic [15:0] RES_BASE = 16'hC3A0; // core code pattern
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic frame_select_n = 1'b1; // frame pin idles high
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, sample_strobe, conv_start, conv_busy, result_valid;
  logic active_bipolar, active_differential, active_range_expand, filter_high_bandwidth;
  logic [15:0] conv_result, result_data;
  logic [2:0] channel_selector_sel, active_channel;
  logic [1:0] active_range_pair;
  logic [31:0] channel_range_code;
  logic [7:0] channel_range_expand;
  int error_cnt = 0, checked = 0;
  adc_channel_range_sequencer #(.NUM_CHANNELS(8)) u_adc_channel_range_sequencer (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .frame_select_n, .conv_result,
    .channel_selector_sel, .sample_strobe, .conv_start, .conv_busy, .result_data, .result_valid,
    .active_channel, .active_bipolar, .active_differential, .active_range_pair, .active_range_expand,
    .channel_range_code, .channel_range_expand, .filter_high_bandwidth);
  adc_core_model #(.BASE(RES_BASE)) u_adc_core_model (.conv_busy, .active_channel, .conv_result);
  always #50 pclk = ~pclk;
  // ------------------------------------------------
  // shared tasks
  // ------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // one apb transfer, entered just after a rising edge; holds until pready
  task automatic apb_xfer(input logic wr, input logic [5:0] idx, input logic [31:0] wd,
    output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1 && n++ < 50);
    if (pready !== 1'b1) error_cnt++; // a bus that never answers counts as a mismatch
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk); // idle cycle keeps strobes from two writes in one step
  endtask : apb_xfer
  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb_xfer(1'b1, idx, d, q, e);
  endtask : wr
  task automatic rd_chk(input string what, input logic [5:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    logic e;
    apb_xfer(1'b0, idx, 32'h0, d, e);
    chk(what, d, exp);
  endtask : rd_chk
  // one frame: pin falls, wait for the strobe, then for the result
  task automatic frame(input logic [2:0] ch);
    int n;
    n = 0;
    frame_select_n <= 1'b0;
    do
      @(posedge pclk);
    while (sample_strobe !== 1'b1 && n++ < 20);
    chk("strobe seen", sample_strobe, 1'b1);
    chk("sampled channel", active_channel, ch);
    chk("valid cleared", result_valid, 1'b0);
    frame_select_n <= 1'b1;
    do
      @(posedge pclk);
    while (conv_busy !== 1'b0 && n++ < 40);
    chk("busy ended", conv_busy, 1'b0);
    chk("result valid", result_valid, 1'b1);
    chk("result data", result_data, RES_BASE | ch);
  endtask : frame
  // ------------------------------------------------
  // scenarios
  // ------------------------------------------------
  task automatic t_reset_vals();
    rd_chk("scan enables", adc_seq_pkg::IDX_SCAN_EN, 32'h0000_00FF);
    rd_chk("expand reset", adc_seq_pkg::IDX_EXPAND, 32'h0);
    rd_chk("filter reset", adc_seq_pkg::IDX_FILTER, 32'h0);
    chk("codes reset", channel_range_code, 32'h0);
  endtask : t_reset_vals
  // every code once, each on its own channel; odd channels expanded
  task automatic t_ranges();
    logic [15:0] pairs = 16'h9124; // range pair per code, code 0 lowest
    for (int i = 0; i < 8; i++)
      wr(6'(adc_seq_pkg::IDX_RANGE_FIRST + i), i);
    wr(adc_seq_pkg::IDX_EXPAND, 32'h0000_00AA);
    chk("expand bits", channel_range_expand, 8'hAA);
    chk("stored codes", channel_range_code, 32'h7654_3210);
    rd_chk("last range", adc_seq_pkg::IDX_RANGE_LAST, 32'h7);
    for (int i = 0; i < 8; i++)
    begin
      wr(adc_seq_pkg::IDX_SEQ_CTRL, i << 4); // manual, channel i
      frame(3'(i));
      chk("bipolar", active_bipolar, !(i == 5 || i == 6));
      chk("differential", active_differential, i == 3 || i == 4 || i == 7);
      chk("range pair", active_range_pair, pairs[2*i +: 2]);
      chk("expand", active_range_expand, i[0]);
    end
  endtask : t_ranges
  // only code one picks the wide filter
  task automatic t_filter();
    for (int v = 0; v < 4; v++)
    begin
      wr(adc_seq_pkg::IDX_FILTER, v);
      @(posedge pclk); // the select flop follows the field one edge later
      chk("filter select", filter_high_bandwidth, v == 1);
    end
  endtask : t_filter
  // sparse scan list checks skipping and the wrap
  task automatic t_auto();
    logic [2:0] seq [6] = '{3'h0, 3'h2, 3'h5, 3'h0, 3'h2, 3'h5};
    wr(adc_seq_pkg::IDX_SCAN_EN, 32'h0000_0025);
    wr(adc_seq_pkg::IDX_SEQ_CTRL, 32'h0); // park on channel 0
    wr(adc_seq_pkg::IDX_SEQ_CTRL, 32'h1); // auto-scan from there
    for (int k = 0; k < 5; k++)
    begin
      frame(seq[k]);
      chk("next channel", channel_selector_sel, seq[k + 1]);
    end
    rd_chk("status", adc_seq_pkg::IDX_STATUS, {RES_BASE | 16'h0002, 16'h0025});
  endtask : t_auto
  task automatic t_unmapped();
    logic [31:0] d;
    logic e;
    apb_xfer(1'b0, 6'h3F, 32'h0, d, e);
    chk("unmapped error", e, 1'b1);
    chk("unmapped data", d, 32'h0);
  endtask : t_unmapped
  task automatic complete_run();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run
  // ------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset_vals();
    t_ranges();
    t_filter();
    t_auto();
    t_unmapped();
    complete_run();
  end
  // whole run needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge pclk);
    error_cnt++;
    complete_run();
  end
endmodule : testbench
